// ===== rtl/aph_pkg.sv
package aph_pkg;
    // ------------------------------------------------------------
    // word layout
    // ------------------------------------------------------------
    localparam int unsigned DATA_W      = 16;
    localparam int unsigned BYTE_W      = 8;
    localparam int unsigned PAYLOAD_W   = 14;
    localparam int unsigned TGT_HI      = 15;
    localparam int unsigned TGT_LO      = 14;
    localparam int unsigned UBE_BIT     = 8;
    localparam int unsigned CAL_REGS    = 10;
    localparam int unsigned CAL_IDX_W   = 4;
    localparam int unsigned RESULT_W    = 12;

    // ------------------------------------------------------------
    // write targets and read selections
    // ------------------------------------------------------------
    localparam logic [1:0] TGT_NONE     = 2'h0;
    localparam logic [1:0] TGT_TEST     = 2'h1;
    localparam logic [1:0] TGT_CAL      = 2'h2;
    localparam logic [1:0] TGT_CTRL     = 2'h3;
    localparam logic [1:0] RSEL_RESULT  = 2'h0;
    localparam logic [1:0] RSEL_TEST    = 2'h1;
    localparam logic [1:0] RSEL_CAL     = 2'h2;
    localparam logic [1:0] RSEL_STATUS  = 2'h3;

    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int unsigned CTL_SGL     = 13;
    localparam int unsigned CTL_CH_HI   = 12;
    localparam int unsigned CTL_CH_LO   = 10;
    localparam int unsigned CTL_PM1     = 9;
    localparam int unsigned CTL_PM0     = 8;
    localparam int unsigned CTL_RS1     = 7;
    localparam int unsigned CTL_RS0     = 6;
    localparam int unsigned CTL_AMODE   = 5;
    localparam int unsigned CTL_CONV    = 4;
    localparam int unsigned CTL_STCAL   = 0;
    localparam logic [13:0] CTL_RESET   = 14'h0000;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned REF_CLK_HZ  = 50_000_000;
    localparam int unsigned MCLK_HZ     = 4_000_000;
    localparam int unsigned MCLK_DIV    = REF_CLK_HZ / MCLK_HZ;
    localparam int unsigned CONV_MCLKS  = 16;
    localparam int unsigned CAL_MCLKS   = 256;
    localparam int unsigned CNT_W       = 9;

    typedef enum logic [1:0] {
        APH_IDLE = 2'b00,
        APH_CONV = 2'b01,
        APH_CAL  = 2'b10
    } aph_op_t;
endpackage

// ===== rtl/aph_bus_if.sv
`timescale 1ns/1ps
interface aph_bus_if;
    logic        cs_n;
    logic        rd_n;
    logic        wr_n;
    logic        word_mode;
    logic [15:0] host_data;
    logic        host_oe_n;
    logic [15:0] dev_data;
    logic        dev_oe_n;
    logic        cal_n;
    logic        busy;
    logic [15:0] bus_level;

    // in byte mode line 8 stays the host's upper-byte enable while the
    // device answers on the low lines only
    assign bus_level[15:8] = (!dev_oe_n && word_mode) ? dev_data[15:8]
                           : (!host_oe_n ? host_data[15:8] : 8'h00);
    assign bus_level[7:0]  = !dev_oe_n ? dev_data[7:0]
                           : (!host_oe_n ? host_data[7:0] : 8'h00);

    modport device (
        input  cs_n, rd_n, wr_n, word_mode, bus_level, cal_n,
        output dev_data, dev_oe_n, busy
    );
    modport host (
        input  bus_level, busy,
        output cs_n, rd_n, wr_n, word_mode, host_data, host_oe_n, cal_n
    );
endinterface

// ===== rtl/aph_device.sv
`timescale 1ns/1ps
module aph_device
    import aph_pkg::*;
#(
    parameter int unsigned MCLK_DIVIDE = aph_pkg::MCLK_DIV
) (
    // clock and reset
    input  wire logic                    ref_clk_i,
    input  wire logic                    reset_i,
    // parallel port
    aph_bus_if.device                    bus,
    // user side
    input  wire logic                    conversion_trigger_i,
    input  wire logic                    sleep_i,
    input  wire logic [aph_pkg::RESULT_W-1:0] sample_i,
    output logic      [1:0]              power_mode_o,
    output logic                         single_ended_o,
    output logic      [2:0]              channel_o,
    output logic                         master_clock_en_o
);
    import aph_pkg::*;

    // ------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------
    logic [6:0]        s1_q, s2_q;
    logic [DATA_W-1:0] d1_q, d2_q;
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            // idle pin levels, so no false edge follows reset
            s1_q <= 7'h7c;
            s2_q <= 7'h7c;
            d1_q <= 16'h0000;
            d2_q <= 16'h0000;
        end else begin
            s1_q <= {bus.cs_n, bus.rd_n, bus.wr_n, bus.word_mode,
                     bus.cal_n, conversion_trigger_i, sleep_i};
            s2_q <= s1_q;
            d1_q <= bus.bus_level;
            d2_q <= d1_q;
        end
    end
    logic cs_n, rd_n, wr_n, word_mode, cal_n, trig, sleep;
    assign {cs_n, rd_n, wr_n, word_mode, cal_n, trig, sleep} = s2_q;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [PAYLOAD_W-1:0] ctrl_q, ctrl_d, test_q, test_d;
    logic [PAYLOAD_W-1:0] cal_q [CAL_REGS];
    logic [PAYLOAD_W-1:0] cal_d [CAL_REGS];
    logic [CAL_IDX_W-1:0] cal_idx_q, cal_idx_d;
    logic [BYTE_W-1:0]    lo_q, lo_d;
    logic                 wr_prev_q, wr_prev_d;
    logic                 cal_prev_q, cal_prev_d;
    logic                 trig_prev_q, trig_prev_d;
    logic                 cs_prev_q, cs_prev_d;
    logic [DATA_W-1:0]    wdat_q, wdat_d;
    logic [7:0]           div_q, div_d;
    logic [CNT_W-1:0]     cnt_q, cnt_d;
    aph_op_t              op_q, op_d;
    logic [DATA_W-1:0]    result_q, result_d;
    logic [DATA_W-1:0]    rdata_q, rdata_d;

    logic                 wr_done, mclk, sw_start, hw_start;
    logic [DATA_W-1:0]    word;
    logic [DATA_W-1:0]    sel_word;
    logic [DATA_W-1:0]    status;

    always_comb begin
        ctrl_d      = ctrl_q;
        test_d      = test_q;
        cal_d       = cal_q;
        cal_idx_d   = cal_idx_q;
        lo_d        = lo_q;
        op_d        = op_q;
        cnt_d       = cnt_q;
        result_d    = result_q;
        wr_prev_d   = wr_n;
        cal_prev_d  = cal_n;
        trig_prev_d = trig;
        cs_prev_d   = cs_n;
        wdat_d      = wdat_q;
        sw_start    = 1'b0;
        word        = 16'h0000;
        // master clock enable from divider
        mclk  = (div_q == 8'(MCLK_DIVIDE - 1));
        div_d = mclk ? 8'h00 : div_q + 8'h01;
        // select and data leave with the strobe, so both are held back
        if (!wr_n && !cs_n) begin
            wdat_d = d2_q;
        end
        wr_done = wr_n && !wr_prev_q && !cs_prev_q;
        if (wr_done) begin
            if (word_mode) begin
                word = wdat_q;
            end else if (!wdat_q[UBE_BIT]) begin
                lo_d = wdat_q[BYTE_W-1:0];
            end else begin
                word = {wdat_q[BYTE_W-1:0], lo_q};
            end
        end
        if (wr_done && (word_mode || wdat_q[UBE_BIT])) begin
            case (word[TGT_HI:TGT_LO])
                TGT_TEST: test_d = word[PAYLOAD_W-1:0];
                TGT_CAL: begin
                    cal_d[cal_idx_q] = word[PAYLOAD_W-1:0];
                    cal_idx_d = (cal_idx_q == CAL_IDX_W'(CAL_REGS - 1))
                              ? 4'h0 : cal_idx_q + 4'h1;
                end
                TGT_CTRL: begin
                    ctrl_d   = word[PAYLOAD_W-1:0];
                    sw_start = word[CTL_CONV];
                    if (word[CTL_STCAL]) begin
                        op_d  = APH_CAL;
                        cnt_d = '0;
                    end
                end
                default: ;
            endcase
        end
        hw_start = trig && !trig_prev_q;
        case (op_q)
            APH_IDLE: begin
                if (hw_start || sw_start) begin
                    op_d  = APH_CONV;
                    cnt_d = '0;
                end
            end
            APH_CONV: begin
                if (mclk) begin
                    cnt_d = cnt_q + 9'h001;
                    if (cnt_q == CNT_W'(CONV_MCLKS - 1)) begin
                        op_d = APH_IDLE;
                        // unipolar straight binary, bipolar twos compl
                        result_d = {4'h0, ctrl_q[CTL_AMODE]
                            ? {~sample_i[RESULT_W-1], sample_i[RESULT_W-2:0]}
                            : sample_i};
                    end
                end
            end
            APH_CAL: begin
                if (mclk) begin
                    cnt_d = cnt_q + 9'h001;
                    if (cnt_q == CNT_W'(CAL_MCLKS - 1)) begin
                        op_d = APH_IDLE;
                    end
                end
            end
            default: op_d = APH_IDLE;
        endcase
        // calibration pin edge overrides everything else
        if (cal_n && !cal_prev_q) begin
            op_d  = APH_CAL;
            cnt_d = '0;
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    assign status = {2'h0, op_q == APH_CAL, op_q == APH_CONV, sleep,
                     ctrl_q[CTL_PM1:CTL_PM0], 5'h00, cal_idx_q};
    always_comb begin
        case (ctrl_q[CTL_RS1:CTL_RS0])
            RSEL_RESULT: sel_word = result_q;
            RSEL_TEST:   sel_word = {2'h0, test_q};
            RSEL_CAL:    sel_word = {2'h0, cal_q[cal_idx_q]};
            RSEL_STATUS: sel_word = status;
            default:     sel_word = 16'h0000;
        endcase
        rdata_d = sel_word;
        if (!word_mode) begin
            // upper-byte enable is sampled from the shared line 8
            rdata_d = {8'h00, d2_q[UBE_BIT] ? sel_word[15:8]
                                            : sel_word[7:0]};
        end
    end

    // ------------------------------------------------------------
    // registers; calibration pin low clears all registers in this block but the calibration registers, the divider and the trigger edge register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            ctrl_q <= CTL_RESET;
            test_q <= '0;
            for (int i = 0; i < CAL_REGS; i++) begin
                cal_q[i] <= '0;
            end
            cal_idx_q   <= '0;
            lo_q        <= '0;
            wr_prev_q   <= 1'b1;
            cal_prev_q  <= 1'b1;
            trig_prev_q <= 1'b0;
            cs_prev_q   <= 1'b1;
            wdat_q      <= '0;
            div_q       <= '0;
            cnt_q       <= '0;
            op_q        <= APH_IDLE;
            result_q    <= '0;
            rdata_q     <= '0;
        end else if (!cal_n) begin
            ctrl_q      <= CTL_RESET;
            test_q      <= '0;
            cal_idx_q   <= '0;
            lo_q        <= '0;
            wr_prev_q   <= 1'b1;
            cal_prev_q  <= 1'b0;
            cs_prev_q   <= 1'b1;
            wdat_q      <= '0;
            cnt_q       <= '0;
            op_q        <= APH_IDLE;
            result_q    <= '0;
            rdata_q     <= '0;
            div_q       <= div_d;
            trig_prev_q <= trig_prev_d;
        end else begin
            ctrl_q      <= ctrl_d;
            test_q      <= test_d;
            cal_q       <= cal_d;
            cal_idx_q   <= cal_idx_d;
            lo_q        <= lo_d;
            wr_prev_q   <= wr_prev_d;
            cal_prev_q  <= cal_prev_d;
            trig_prev_q <= trig_prev_d;
            cs_prev_q   <= cs_prev_d;
            wdat_q      <= wdat_d;
            div_q       <= div_d;
            cnt_q       <= cnt_d;
            op_q        <= op_d;
            result_q    <= result_d;
            rdata_q     <= rdata_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign bus.dev_data = rdata_q;
    assign bus.dev_oe_n = cs_n || rd_n || !wr_n;
    assign bus.busy     = (op_q != APH_IDLE);
    // power mode combines sleep with the two control bits
    assign power_mode_o = sleep ? ctrl_q[CTL_PM1:CTL_PM0] : 2'h0;
    assign single_ended_o    = ctrl_q[CTL_SGL];
    assign channel_o         = ctrl_q[CTL_CH_HI:CTL_CH_LO];
    assign master_clock_en_o = mclk;
endmodule

// ===== rtl/aph_host.sv
`timescale 1ns/1ps
module aph_host
    import aph_pkg::*;
#(
    parameter int unsigned STROBE_CYC = 8
) (
    // clock and reset
    input  wire logic                  ref_clk_i,
    input  wire logic                  reset_i,
    // port
    aph_bus_if.host                    bus,
    // user side
    input  wire logic                  req_i,
    input  wire logic                  we_i,
    input  wire logic                  word_mode_i,
    input  wire logic [15:0]           wdata_i,
    input  wire logic                  cal_n_i,
    output logic                       ready_o,
    output logic      [15:0]           rdata_o,
    output logic                       done_o,
    output logic                       busy_o
);
    import aph_pkg::*;

    typedef enum logic [1:0] {
        AH_IDLE = 2'b00,
        AH_ACT  = 2'b01,
        AH_GAP  = 2'b10
    } aph_hst_t;

    aph_hst_t    st_q, st_d;
    logic [7:0]  cnt_q, cnt_d;
    logic        we_q, we_d, wm_q, wm_d, hi_q, hi_d, done_q, done_d;
    logic [15:0] wd_q, wd_d, rd_q, rd_d;
    logic        b1_q, b2_q;

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            b1_q <= 1'b0;
            b2_q <= 1'b0;
        end else begin
            b1_q <= bus.busy;
            b2_q <= b1_q;
        end
    end

    always_comb begin
        st_d = st_q; cnt_d = cnt_q; we_d = we_q; wm_d = wm_q;
        hi_d = hi_q; wd_d = wd_q; rd_d = rd_q; done_d = 1'b0;
        case (st_q)
            AH_IDLE: if (req_i) begin
                st_d = AH_ACT; cnt_d = '0; we_d = we_i;
                wm_d = word_mode_i; wd_d = wdata_i; hi_d = 1'b0;
            end
            AH_ACT: begin
                cnt_d = cnt_q + 8'h01;
                if (cnt_q == 8'(STROBE_CYC - 1)) begin
                    if (!we_q) begin
                        if (wm_q) rd_d = bus.bus_level;
                        else if (hi_q) rd_d[15:8] = bus.bus_level[7:0];
                        else rd_d[7:0] = bus.bus_level[7:0];
                    end
                    st_d = AH_GAP; cnt_d = '0;
                end
            end
            AH_GAP: begin
                cnt_d = cnt_q + 8'h01;
                if (cnt_q == 8'(STROBE_CYC - 1)) begin
                    if (!wm_q && !hi_q) begin
                        hi_d = 1'b1; st_d = AH_ACT; cnt_d = '0;
                    end else begin
                        st_d = AH_IDLE; done_d = 1'b1;
                    end
                end
            end
            default: st_d = AH_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            st_q <= AH_IDLE; cnt_q <= '0; we_q <= 1'b0; wm_q <= 1'b1;
            hi_q <= 1'b0; wd_q <= '0; rd_q <= '0; done_q <= 1'b0;
        end else begin
            st_q <= st_d; cnt_q <= cnt_d; we_q <= we_d; wm_q <= wm_d;
            hi_q <= hi_d; wd_q <= wd_d; rd_q <= rd_d; done_q <= done_d;
        end
    end

    logic act;
    assign act           = (st_q == AH_ACT);
    assign bus.cs_n      = !act;
    assign bus.rd_n      = !(act && !we_q);
    assign bus.wr_n      = !(act && we_q);
    assign bus.word_mode = wm_q;
    assign bus.cal_n     = cal_n_i;
    // byte mode: line 8 carries upper-byte enable; low byte first
    assign bus.host_data = wm_q ? wd_q
        : {7'h00, hi_q, hi_q ? wd_q[15:8] : wd_q[7:0]};
    assign bus.host_oe_n = !((act && we_q) || (st_q != AH_IDLE && !wm_q));
    assign ready_o       = (st_q == AH_IDLE);
    assign rdata_o       = rd_q;
    assign done_o        = done_q;
    assign busy_o        = b2_q;
endmodule

// ===== bench/aph_props.sv
`timescale 1ns/1ps
module aph_props (
    // clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        reset_i,
    // port signals
    input  wire logic        cs_n,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    input  wire logic [15:0] host_data,
    input  wire logic        host_oe_n,
    input  wire logic        dev_oe_n,
    input  wire logic        cal_n,
    input  wire logic        busy
);
    // calibration of 256 master periods at divide 12, plus sync slack
    localparam int BUSY_MAX = 3300;

    logic [3:0]  rel_q;
    logic [3:0]  cal_lo_q;
    logic [11:0] busy_q;

    // ------------------------------------------------------------
    // helper counters
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rel_q    <= 4'h0;
            cal_lo_q <= 4'h0;
            busy_q   <= 12'h000;
        end else begin
            rel_q    <= (!cs_n && !rd_n) ? 4'h0 : rel_q + {3'h0, rel_q != 4'hf};
            cal_lo_q <= cal_n ? 4'h0 : cal_lo_q + {3'h0, cal_lo_q != 4'hf};
            busy_q   <= busy ? busy_q + {11'h000, busy_q != 12'hfff} : 12'h000;
        end
    end

    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_wr_select: assert property (!wr_n |-> !cs_n)
        else $error("write strobe without chip select");
    a_rd_select: assert property (!rd_n |-> !cs_n)
        else $error("read strobe without chip select");
    a_no_clash: assert property (!(!rd_n && !wr_n))
        else $error("read and write strobes low together");
    a_wr_width: assert property ($fell(wr_n) |-> (!wr_n)[*8] ##1 wr_n)
        else $error("write strobe width wrong");
    a_rd_width: assert property ($fell(rd_n) |-> (!rd_n)[*8] ##1 rd_n)
        else $error("read strobe width wrong");
    a_wdata_hold: assert property ((!wr_n && !$past(wr_n)) |->
        ($stable(host_data) && !host_oe_n))
        else $error("write data moved under strobe");
    a_dev_quiet: assert property (!wr_n |-> dev_oe_n)
        else $error("device drives during a write");
    a_dev_release: assert property (rel_q >= 4'h5 |-> dev_oe_n)
        else $error("device drives outside a selected read");
    a_cal_start: assert property (($rose(cal_n) && cal_lo_q >= 4'h3)
        |-> ##[1:8] busy)
        else $error("no busy after calibration edge");
    a_cal_clear: assert property (cal_lo_q >= 4'h4 |-> !busy)
        else $error("busy while calibration pin low");
    a_busy_hold: assert property ($rose(busy) |-> busy[*8])
        else $error("busy pulse too short");
    a_busy_span: assert property (busy_q <= BUSY_MAX)
        else $error("busy held too long");
endmodule

// ===== bench/tb_adc_parallel_host_interface.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) \
    begin \
        checks_done++; \
        if ((g) !== (e)) begin \
            failures++; \
            $display("[ERR] %s expected %h seen %h", nm, e, g); \
        end \
    end
module tb_adc_parallel_host_interface;
    import aph_pkg::*;

    logic        ref_clk_i;
    logic        reset_i;
    logic        req_i;
    logic        we_i;
    logic        word_mode_i;
    logic [15:0] wdata_i;
    logic        cal_n_i;
    logic        ready_o;
    logic [15:0] rdata_o;
    logic        done_o;
    logic        busy_o;
    logic        conversion_trigger_i;
    logic        sleep_i;
    logic [11:0] sample_i;
    logic [1:0]  power_mode_o;
    logic        single_ended_o;
    logic [2:0]  channel_o;
    logic        master_clock_en_o;
    logic [15:0] rd;
    int          failures = 0;
    int          checks_done = 0;
    int          gap = 0;

    aph_bus_if bus_if ();
    aph_device aph_device_inst (.ref_clk_i, .reset_i, .bus(bus_if),
        .conversion_trigger_i, .sleep_i, .sample_i, .power_mode_o,
        .single_ended_o, .channel_o, .master_clock_en_o);
    aph_host aph_host_inst (.ref_clk_i, .reset_i, .bus(bus_if), .req_i,
        .we_i, .word_mode_i, .wdata_i, .cal_n_i, .ready_o, .rdata_o,
        .done_o, .busy_o);
    aph_props aph_props_inst (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
        .cs_n(bus_if.cs_n), .rd_n(bus_if.rd_n), .wr_n(bus_if.wr_n),
        .host_data(bus_if.host_data), .host_oe_n(bus_if.host_oe_n),
        .dev_oe_n(bus_if.dev_oe_n), .cal_n(bus_if.cal_n),
        .busy(bus_if.busy));

    initial begin
        ref_clk_i = 1'b0;
        forever #10 ref_clk_i = ~ref_clk_i;
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic close_out;
        if (failures == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // one host access; entered just after a rising edge
    task automatic xfer(input logic we, input logic wm,
                        input logic [15:0] wd, output logic [15:0] r);
        int n;
        n = 0;
        while (ready_o !== 1'b1 && n < 100) begin
            @(posedge ref_clk_i);
            n++;
        end
        req_i       <= 1'b1;
        we_i        <= we;
        word_mode_i <= wm;
        wdata_i     <= wd;
        @(posedge ref_clk_i);
        req_i <= 1'b0;
        n = 0;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (done_o !== 1'b1 && n < 100);
        `CHK("done", 1'b1, done_o)
        r = rdata_o;
    endtask

    task automatic wait_busy(input logic lvl, input int lim);
        int n;
        n = 0;
        while (busy_o !== lvl && n < lim) begin
            @(posedge ref_clk_i);
            n++;
        end
        `CHK("busy", lvl, busy_o)
    endtask

    // master enable spacing; restarts whenever calibration pin is low
    always @(posedge ref_clk_i) begin
        if (reset_i || !cal_n_i) begin
            gap = 0;
        end else if (master_clock_en_o === 1'b1) begin
            if (gap != 0) `CHK("mclk gap", MCLK_DIV, gap)
            gap = 1;
        end else if (gap != 0) begin
            gap++;
        end
    end

    initial begin
        repeat (20000) @(posedge ref_clk_i);
        failures++;
        $display("[ERR] watchdog expected %h seen %h", 1'b1, 1'b0);
        close_out();
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        reset_i = 1'b1;
        req_i = 1'b0;
        we_i = 1'b0;
        word_mode_i = 1'b1;
        wdata_i = 16'h0000;
        cal_n_i = 1'b1;
        conversion_trigger_i = 1'b0;
        sleep_i = 1'b0;
        sample_i = 12'ha5c;
        repeat (5) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        @(posedge ref_clk_i);
        `CHK("ready", 1'b1, ready_o)
        `CHK("sgl", 1'b0, single_ended_o)
        `CHK("chan", 3'h0, channel_o)
        conversion_trigger_i <= 1'b1;
        wait_busy(1'b1, 20);
        wait_busy(1'b0, 400);
        conversion_trigger_i <= 1'b0;
        xfer(1'b0, 1'b1, 16'h0000, rd);
        `CHK("res word", {4'h0, sample_i}, rd)
        xfer(1'b0, 1'b0, 16'h0000, rd);
        `CHK("res byte", {4'h0, sample_i}, rd)
        // single-ended, pair 5, power bits 2, readback of test register
        xfer(1'b1, 1'b1, {TGT_CTRL, 1'b1, 3'h5, 2'h2, 2'h1, 6'h00}, rd);
        `CHK("sgl", 1'b1, single_ended_o)
        `CHK("chan", 3'h5, channel_o)
        `CHK("pm awake", 2'h0, power_mode_o)
        sleep_i <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        `CHK("pm sleep", 2'h2, power_mode_o)
        sleep_i <= 1'b0;
        xfer(1'b1, 1'b0, {TGT_TEST, 14'h1234}, rd);
        xfer(1'b1, 1'b1, {TGT_NONE, 14'h3fff}, rd);
        xfer(1'b0, 1'b1, 16'h0000, rd);
        `CHK("test reg", 14'h1234, rd[13:0])
        // bipolar coding with a software start
        xfer(1'b1, 1'b1, {TGT_CTRL, 1'b1, 3'h5, 4'h0, 2'h3, 4'h0}, rd);
        wait_busy(1'b1, 20);
        wait_busy(1'b0, 400);
        xfer(1'b0, 1'b1, 16'h0000, rd);
        `CHK("bipolar", {4'h0, ~sample_i[11], sample_i[10:0]}, rd)
        // calibration pin cuts a running conversion and clears settings
        conversion_trigger_i <= 1'b1;
        wait_busy(1'b1, 20);
        cal_n_i <= 1'b0;
        conversion_trigger_i <= 1'b0;
        repeat (10) @(posedge ref_clk_i);
        `CHK("busy cut", 1'b0, busy_o)
        `CHK("sgl clr", 1'b0, single_ended_o)
        `CHK("chan clr", 3'h0, channel_o)
        cal_n_i <= 1'b1;
        wait_busy(1'b1, 20);
        wait_busy(1'b0, 3400);
        close_out();
    end
endmodule
